/* File: rtl/tdcab_pkg.sv */
// Package of constants for the time-to-digital converter acquisition and buffer control.
package tdcab_pkg;
   localparam int unsigned TDCAB_CLK_HZ = 10000000;
   localparam int unsigned TDCAB_CHANNELS = 96;
   localparam int unsigned TDCAB_DEPTH = 4;
   localparam int unsigned TDCAB_AW = 2;
   // Register byte offsets.
   localparam logic [7:0] TDCAB_OFS_MAIN = 8'h00;
   localparam logic [7:0] TDCAB_OFS_ACQ = 8'h04;
   localparam logic [7:0] TDCAB_OFS_LADDR = 8'h0c;
   localparam logic [7:0] TDCAB_OFS_BCLASS = 8'h1c;
   localparam logic [7:0] TDCAB_OFS_RANGE = 8'h48;
   localparam logic [7:0] TDCAB_OFS_STAT = 8'h50;
   localparam logic [7:0] TDCAB_OFS_IRQ = 8'h54;
   localparam logic [7:0] TDCAB_OFS_MASK = 8'h58;
   localparam logic [7:0] TDCAB_OFS_READ = 8'h5c;
   localparam logic [7:0] TDCAB_OFS_AUX_LO = 8'h80;
   localparam logic [7:0] TDCAB_OFS_AUX_HI = 8'hbc;
   // Field positions.
   localparam int unsigned TDCAB_ACQ_MODE_BIT = 31;
   localparam int unsigned TDCAB_ACQ_RISE_BIT = 30;
   localparam int unsigned TDCAB_ACQ_FALL_BIT = 29;
   localparam int unsigned TDCAB_MAIN_CLEAR_BIT = 31;
   localparam int unsigned TDCAB_MAIN_MRST_BIT = 30;
   localparam int unsigned TDCAB_MAIN_LNE_BIT = 2;
   localparam int unsigned TDCAB_MAIN_COM_BIT = 23;
   localparam int unsigned TDCAB_ID_LSB = 16;
   // Reset values.
   localparam logic [31:0] TDCAB_ACQ_RST = 32'h00000000;
   localparam logic [31:0] TDCAB_RANGE_RST = 32'h0000ffff;
   localparam logic [15:0] TDCAB_ID_DEFAULT = 16'h5a5a;
   // Timing.
   localparam int unsigned TDCAB_BIP_CLR_NS = 75;
   localparam int unsigned TDCAB_BIP_CLR_CYC =
      (TDCAB_BIP_CLR_NS * (TDCAB_CLK_HZ / 1000000)) / 1000 < 1 ? 1 :
      (TDCAB_BIP_CLR_NS * (TDCAB_CLK_HZ / 1000000)) / 1000;
   localparam int unsigned TDCAB_REARM_NS = 250;
   localparam int unsigned TDCAB_REARM_CYC =
      (TDCAB_REARM_NS * (TDCAB_CLK_HZ / 1000000) + 999) / 1000;
   localparam int unsigned TDCAB_BUF_MAX_NS = 78000;
   localparam int unsigned TDCAB_BUF_MAX_CYC =
      (TDCAB_BUF_MAX_NS * (TDCAB_CLK_HZ / 1000000)) / 1000;
   localparam int unsigned TDCAB_READY_NS = 500;
   localparam int unsigned TDCAB_READY_CYC =
      (TDCAB_READY_NS * (TDCAB_CLK_HZ / 1000000) + 999) / 1000;
   localparam int unsigned TDCAB_HIT_CYC = 8;
   // Interrupt bits.
   localparam int unsigned TDCAB_IRQ_DONE = 0;
   localparam int unsigned TDCAB_IRQ_FULL = 1;
   localparam int unsigned TDCAB_IRQ_CLEAR = 2;
   typedef enum logic [1:0] {
      TDCAB_IDLE = 2'b00,
      TDCAB_ACQ = 2'b01,
      TDCAB_BUF = 2'b10,
      TDCAB_REARM = 2'b11
   } tdcab_state_t;
endpackage

/* File: rtl/tdcab_mem_if.sv */
// Interface between the control logic and the event count memory.
`timescale 1ns/1ps
`default_nettype none
interface tdcab_mem_if;
   logic we;
   logic [1:0] waddr;
   logic [7:0] wdata;
   logic [1:0] raddr;
   logic [7:0] rdata;
   modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
   modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface
`default_nettype wire

/* File: rtl/tdcab_mem.sv */
// Event memory holding the hit count of each buffered event.
`timescale 1ns/1ps
`default_nettype none
module tdcab_mem
(
   input wire logic clk,
   tdcab_mem_if.mem m
);
   logic [7:0] store_r [0:3];
   logic [7:0] rd_r;
   always_ff @(posedge clk)
   begin
      if (m.we)
      begin
         store_r[m.waddr] <= m.wdata;
      end
   end
   always_ff @(posedge clk)
   begin
      rd_r <= store_r[m.raddr];
   end
   assign m.rdata = rd_r;
endmodule
`default_nettype wire

/* File: rtl/tdcab_ctrl.sv */
// Acquisition, event buffering and register control of the converter.
`timescale 1ns/1ps
`default_nettype none
module tdcab_ctrl
   import tdcab_pkg::*;
#(
   parameter int unsigned CHANNELS = TDCAB_CHANNELS,
   parameter logic [15:0] ID_CODE = TDCAB_ID_DEFAULT,
   parameter int unsigned BUF_MAX_CYC = TDCAB_BUF_MAX_CYC
)
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [CHANNELS-1:0] hit_in,
   input wire logic com_in,
   input wire logic timeout_in,
   input wire logic clear_in,
   output logic buffering_in_progress_out,
   output logic event_ready_out,
   output logic irq
);
   // ID_CODE default is arbitrary.
   tdcab_mem_if mi();
   tdcab_state_t state_r;
   logic [31:0] main_r, acq_r, laddr_r, bclass_r, range_r;
   logic [2:0] irq_r, mask_r;
   logic programmed_r;
   logic [7:0] hits_r;
   logic [16:0] buf_cnt_r;
   logic [3:0] rearm_cnt_r;
   logic [3:0] ready_cnt_r;
   logic [1:0] wp_r, rp_r;
   logic [2:0] used_r;
   logic clear_d_r;
   logic wr, rd;
   logic clr_pulse, clr_rise, com_evt, lne;
   logic [CHANNELS-1:0] hit_d_r;
   logic [CHANNELS-1:0] edge_hit;
   logic [7:0] n_hits;
   logic full, done, bip_nxt;
   logic [31:0] rd_nxt;

   assign wr = psel && penable && pwrite;
   assign rd = psel && !penable && !pwrite;
   assign clr_pulse = wr && paddr == TDCAB_OFS_MAIN && pwdata[TDCAB_MAIN_CLEAR_BIT];
   assign clr_rise = (clear_in && !clear_d_r) || clr_pulse;
   assign com_evt = com_in || (wr && paddr == TDCAB_OFS_MAIN && pwdata[TDCAB_MAIN_COM_BIT]);
   assign lne = wr && paddr == TDCAB_OFS_MAIN && pwdata[TDCAB_MAIN_LNE_BIT]
      && used_r != 3'd0;
   assign full = used_r == 3'(TDCAB_DEPTH);
   // Slowdown while reading: buffering waits when the bus is busy.
   assign done = state_r == TDCAB_BUF && !(psel && penable) &&
      (buf_cnt_r >= 17'({hits_r, 1'b0}) || buf_cnt_r >= 17'(BUF_MAX_CYC - 1));

   // Edge selection applies to every channel alike.
   genvar g;
   generate
      for (g = 0; g < CHANNELS; g++)
      begin : g_edge
         assign edge_hit[g] = (acq_r[TDCAB_ACQ_RISE_BIT] && hit_in[g] && !hit_d_r[g]) ||
            (acq_r[TDCAB_ACQ_FALL_BIT] && !hit_in[g] && hit_d_r[g]);
      end
   endgenerate

   always_comb
   begin
      n_hits = 8'h00;
      for (int i = 0; i < CHANNELS; i++)
      begin
         n_hits = n_hits + 8'(edge_hit[i]);
      end
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         hit_d_r <= '0;
         clear_d_r <= 1'b0;
      end
      else
      begin
         hit_d_r <= hit_in;
         clear_d_r <= clear_in;
      end
   end

   // Acquisition and buffering sequencer.
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state_r <= TDCAB_IDLE;
         hits_r <= 8'h00;
         buf_cnt_r <= 17'h00000;
         rearm_cnt_r <= 4'h0;
      end
      else if (clr_rise && state_r != TDCAB_BUF)
      begin
         state_r <= TDCAB_REARM;
         hits_r <= 8'h00;
         rearm_cnt_r <= 4'h0;
      end
      else
      begin
         unique case (state_r)
            TDCAB_IDLE:
            begin
               if (programmed_r && !full)
               begin
                  state_r <= TDCAB_ACQ;
               end
            end
            TDCAB_ACQ:
            begin
               // Channel hits act as stop or start against the common pulse.
               if (hits_r + n_hits >= hits_r)
               begin
                  hits_r <= hits_r + n_hits;
               end
               if ((acq_r[TDCAB_ACQ_MODE_BIT] && timeout_in) ||
                  (!acq_r[TDCAB_ACQ_MODE_BIT] && com_evt))
               begin
                  state_r <= TDCAB_BUF;
                  buf_cnt_r <= 17'h00000;
               end
            end
            TDCAB_BUF:
            begin
               buf_cnt_r <= buf_cnt_r + 17'h00001;
               if (done)
               begin
                  state_r <= TDCAB_IDLE;
                  hits_r <= 8'h00;
               end
            end
            TDCAB_REARM:
            begin
               if (clear_in)
               begin
                  rearm_cnt_r <= 4'h0;
               end
               else if (rearm_cnt_r >= 4'(TDCAB_REARM_CYC - 1))
               begin
                  state_r <= TDCAB_IDLE;
               end
               else
               begin
                  rearm_cnt_r <= rearm_cnt_r + 4'h1;
               end
            end
         endcase
      end
   end

   // Buffer bookkeeping.
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         wp_r <= 2'b00;
         rp_r <= 2'b00;
         used_r <= 3'd0;
      end
      else
      begin
         if (done)
         begin
            wp_r <= wp_r + 2'b01;
         end
         if (lne)
         begin
            rp_r <= rp_r + 2'b01;
         end
         used_r <= used_r + 3'(done) - 3'(lne);
      end
   end
   assign mi.we = done;
   assign mi.waddr = wp_r;
   assign mi.wdata = hits_r;
   assign mi.raddr = rp_r;

   tdcab_mem u_mem
   (
      .clk(clk),
      .m(mi)
   );

   // Readout holdoff after an event lands in the buffer.
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         ready_cnt_r <= 4'h0;
         event_ready_out <= 1'b0;
      end
      else
      begin
         if (done)
         begin
            ready_cnt_r <= 4'(TDCAB_READY_CYC);
         end
         else if (ready_cnt_r != 4'h0)
         begin
            ready_cnt_r <= ready_cnt_r - 4'h1;
         end
         event_ready_out <= used_r != 3'd0 && ready_cnt_r == 4'h0 && !done;
      end
   end

   assign bip_nxt = !clr_rise && (state_r == TDCAB_BUF && !done || full);
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         buffering_in_progress_out <= 1'b0;
      end
      else
      begin
         buffering_in_progress_out <= bip_nxt;
      end
   end

   // Control registers.
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         main_r <= 32'h00000000;
         acq_r <= TDCAB_ACQ_RST;
         laddr_r <= 32'h00000000;
         bclass_r <= 32'h00000000;
         range_r <= TDCAB_RANGE_RST;
         mask_r <= 3'b000;
         programmed_r <= 1'b0;
      end
      else if (wr && paddr == TDCAB_OFS_MAIN && pwdata[TDCAB_MAIN_MRST_BIT])
      begin
         main_r <= 32'h00000000;
         acq_r <= TDCAB_ACQ_RST;
         bclass_r <= 32'h00000000;
         range_r <= TDCAB_RANGE_RST;
         programmed_r <= 1'b0;
      end
      else if (wr)
      begin
         unique case (paddr)
            TDCAB_OFS_MAIN: main_r <= {16'h0000, pwdata[15:0]};
            TDCAB_OFS_ACQ:
            begin
               acq_r <= pwdata;
               programmed_r <= 1'b1;
            end
            TDCAB_OFS_LADDR: laddr_r <= {pwdata[31:16], 16'h0000};
            TDCAB_OFS_BCLASS: bclass_r <= pwdata;
            TDCAB_OFS_RANGE: range_r <= pwdata;
            TDCAB_OFS_MASK: mask_r <= pwdata[2:0];
            default:
            begin
            end
         endcase
      end
   end

   // Sticky interrupt status; a new event wins over a clear.
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         irq_r <= 3'b000;
         irq <= 1'b0;
      end
      else
      begin
         irq_r <= (irq_r & ~((wr && paddr == TDCAB_OFS_IRQ) ? pwdata[2:0] : 3'b000))
            | {clr_rise, full, done};
         irq <= |(irq_r & mask_r);
      end
   end

   always_comb
   begin
      unique case (paddr)
         TDCAB_OFS_MAIN: rd_nxt = {ID_CODE, main_r[15:0]};
         TDCAB_OFS_ACQ: rd_nxt = acq_r;
         TDCAB_OFS_LADDR: rd_nxt = laddr_r;
         TDCAB_OFS_BCLASS: rd_nxt = bclass_r;
         TDCAB_OFS_RANGE: rd_nxt = range_r;
         TDCAB_OFS_STAT: rd_nxt = {26'h0000000, used_r, state_r, buffering_in_progress_out};
         TDCAB_OFS_IRQ: rd_nxt = {29'h00000000, irq_r};
         TDCAB_OFS_MASK: rd_nxt = {29'h00000000, mask_r};
         TDCAB_OFS_READ: rd_nxt = {24'h000000, mi.rdata};
         default: rd_nxt = 32'h00000000;
      endcase
   end

   // Two-cycle APB: data latched in setup, ready in access.
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         if (rd)
         begin
            prdata <= rd_nxt;
         end
         pready <= psel && !penable;
         // Auxiliary card locations answer zero without error; other locations above the read register fail.
         pslverr <= psel && !penable && paddr > TDCAB_OFS_READ &&
            !(paddr >= TDCAB_OFS_AUX_LO && paddr <= TDCAB_OFS_AUX_HI);
      end
   end
endmodule
`default_nettype wire

/* File: test/tdcab_checker.sv */
// Checker of the bus handshake and readout relations of the control block.
`timescale 1ns/1ps
`default_nettype none
module tdcab_checker
   import tdcab_pkg::*;
#(
   parameter logic [15:0] ID_CODE = TDCAB_ID_DEFAULT
)
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic buffering_in_progress_out,
   input wire logic event_ready_out
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   sequence setup_s;
      psel && !penable;
   endsequence
   sequence answer_s;
      psel && penable && pready;
   endsequence
   sequence read_s(logic [7:0] a);
      pready && !pwrite && paddr == a;
   endsequence
   ans_time_a: assert property (setup_s |=> answer_s)
      else $error("No answer one cycle after setup.");
   ans_pulse_a: assert property (pready |=> !pready)
      else $error("Ready held too long.");
   ans_phase_a: assert property (pready |-> psel && penable)
      else $error("Ready outside access phase.");
   err_with_a: assert property (pslverr |-> pready)
      else $error("Error without ready.");
   id_code_a: assert property (read_s(TDCAB_OFS_MAIN) |-> prdata[31:16] == ID_CODE)
      else $error("Wrong identification code.");
   unmapped_err_a: assert property (read_s(8'h60) |-> pslverr && prdata == 32'h0)
      else $error("Unmapped read not refused.");
   aux_zero_a: assert property (pready && !pwrite && paddr inside
      {[TDCAB_OFS_AUX_LO:TDCAB_OFS_AUX_HI]} |-> !pslverr && prdata == 32'h0)
      else $error("Auxiliary read wrong.");
   ready_gap_a: assert property ($rose(event_ready_out) |->
      !$past(buffering_in_progress_out, 6))
      else $error("Event offered too soon.");
endmodule
bind tdcab_ctrl tdcab_checker #(.ID_CODE(ID_CODE)) chk (.clk, .nrst, .psel, .penable,
   .pwrite, .paddr, .prdata, .pready, .pslverr, .buffering_in_progress_out,
   .event_ready_out);
`default_nettype wire

/* File: test/tdcab_master.sv */
// Bus master model that programs the block and reads out buffered events.
`timescale 1ns/1ps
`default_nettype none
module tdcab_master
   import tdcab_pkg::*;
(
   input wire logic clk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic event_ready_out
);
   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
   end
   task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do
         @(posedge clk);
      while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~a;
      pwdata <= ~d;
   endtask
   task automatic setup(input logic [31:0] acq);
      logic [31:0] q;
      logic e;
      xf(1'b1, TDCAB_OFS_MAIN, 32'h0, q, e);
      xf(1'b1, TDCAB_OFS_LADDR, 32'h12340000, q, e);
      xf(1'b1, TDCAB_OFS_BCLASS, 32'h1, q, e);
      xf(1'b1, TDCAB_OFS_ACQ, acq, q, e);
   endtask
   task automatic rd_ev(output logic [31:0] n);
      logic [31:0] q;
      logic e;
      while (event_ready_out !== 1'b1)
         @(posedge clk);
      xf(1'b0, TDCAB_OFS_READ, 32'h0, n, e);
      xf(1'b1, TDCAB_OFS_MAIN, 32'h4, q, e);
   endtask
endmodule
`default_nettype wire

/* File: test/tdc_acquire_buffer_control_test.sv */
// Self-checking bench of the acquisition and buffer control.
`timescale 1ns/1ps
`default_nettype none
module tdc_acquire_buffer_control_test
   import tdcab_pkg::*;
;
   localparam logic [15:0] ID = 16'h2b71; // Arbitrary identification value.
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [TDCAB_CHANNELS-1:0] hit_in = '0;
   logic com_in = 1'b0;
   logic timeout_in = 1'b0;
   logic clear_in = 1'b0;
   wire logic psel, penable, pwrite, pready, pslverr, busy, evr, irq;
   wire logic [7:0] paddr;
   wire logic [31:0] pwdata, prdata;
   int miscompares = 0;
   int checked = 0;
   int seed = 44;
   int cyc = 0;
   int q[$];
   logic [31:0] r;
   logic e;
   tdcab_ctrl #(.ID_CODE(ID)) DUT (.clk, .nrst, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .hit_in, .com_in, .timeout_in, .clear_in,
      .buffering_in_progress_out(busy), .event_ready_out(evr), .irq);
   tdcab_master m (.clk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .event_ready_out(evr));
   initial
   begin
      forever #50 clk = ~clk;
   end
   task automatic complete_run();
      $display("Counts: checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         miscompares++;
         complete_run();
      end
   end
   task automatic cw(input string s, input logic [31:0] x, input logic [31:0] y);
      checked++;
      if (y !== x)
      begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", s, x, y);
      end
   endtask
   task automatic cb(input string s, input logic x, input logic y);
      cw(s, {31'h0, x}, {31'h0, y});
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] x, input logic [31:0] k,
      input logic xe);
      m.xf(1'b0, a, 32'h0, r, e);
      cw($sformatf("data %h", a), x & k, r & k);
      cb($sformatf("error %h", a), xe, e);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      m.xf(1'b1, a, d, r, e);
      repeat (2) @(negedge clk);
   endtask
   task automatic hits(input int n);
      int b;
      b = {$random(seed)} % TDCAB_CHANNELS;
      for (int i = 0; i < n; i++)
      begin
         @(posedge clk);
         hit_in[(b + i) % TDCAB_CHANNELS] <= 1'b1;
         repeat (2) @(posedge clk);
         hit_in[(b + i) % TDCAB_CHANNELS] <= 1'b0;
      end
   endtask
   task automatic pl(input logic c, input logic t);
      repeat (2) @(posedge clk);
      com_in <= c;
      timeout_in <= t;
      @(posedge clk);
      com_in <= 1'b0;
      timeout_in <= 1'b0;
   endtask
   task automatic meas(output int d);
      int k;
      k = 0;
      d = 0;
      while (busy !== 1'b1 && k < 8)
      begin
         @(negedge clk);
         k++;
      end
      while (busy === 1'b1)
      begin
         @(negedge clk);
         d++;
      end
   endtask
   task automatic clr();
      @(posedge clk);
      clear_in <= 1'b1;
      @(negedge clk);
      @(negedge clk);
      cb("clear_busy", 1'b0, busy);
      @(posedge clk);
      clear_in <= 1'b0;
      repeat (6) @(posedge clk);
   endtask
   task automatic ev_chk();
      logic [31:0] v;
      m.rd_ev(v);
      cw("count", q.pop_front(), v);
   endtask
   initial
   begin
      int n;
      int d;
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      rc(TDCAB_OFS_ACQ, TDCAB_ACQ_RST, '1, 1'b0);
      rc(TDCAB_OFS_RANGE, TDCAB_RANGE_RST, '1, 1'b0);
      rc(TDCAB_OFS_MAIN, {ID, 16'h0}, 32'hffff0000, 1'b0);
      rc(8'h60, 32'h0, '1, 1'b1);
      for (int i = 0; i < 16; i++)
         rc(TDCAB_OFS_AUX_LO + 8'(4 * i), 32'h0, '1, 1'b0);
      hits(2);
      pl(1'b1, 1'b0);
      rc(TDCAB_OFS_STAT, 32'h0, 32'h3f, 1'b0);
      $display("Test setup finished");
      m.setup(32'h40000000);
      rc(TDCAB_OFS_ACQ, 32'h40000000, '1, 1'b0);
      n = 1 + {$random(seed)} % 8;
      hits(n);
      pl(1'b1, 1'b0);
      q.push_back(n);
      meas(d);
      cb("buf_time", 1'b1, d >= 2 * n && d <= 2 * n + 2);
      rc(TDCAB_OFS_IRQ, 32'h1, 32'h1, 1'b0);
      cb("irq_masked", 1'b0, irq);
      wr(TDCAB_OFS_MASK, 32'h1);
      cb("irq_on", 1'b1, irq);
      wr(TDCAB_OFS_IRQ, 32'h1);
      cb("irq_off", 1'b0, irq);
      $display("Test stop mode finished");
      m.setup(32'he0000000);
      pl(1'b1, 1'b0);
      repeat (4) @(negedge clk);
      cb("start_com", 1'b0, busy);
      n = 16 + {$random(seed)} % 8;
      hits(n);
      pl(1'b0, 1'b1);
      q.push_back(2 * n);
      fork
         meas(d);
         begin
            ev_chk();
            repeat (4) rc(TDCAB_OFS_STAT, 32'h1, 32'h1, 1'b0);
         end
      join
      cb("slowed", 1'b1, d >= 4 * n && d <= 4 * n + 1);
      $display("Test start mode finished");
      for (int k = 0; k < 4; k++)
      begin
         n = 1 + {$random(seed)} % 8;
         pl(1'b1, 1'b0);
         hits(n);
         pl(1'b0, 1'b1);
         if (k < 3)
            q.push_back(2 * n);
         repeat (40) @(negedge clk);
      end
      cb("full", 1'b1, busy);
      rc(TDCAB_OFS_IRQ, 32'h2, 32'h2, 1'b0);
      clr();
      repeat (4) ev_chk();
      repeat (8) @(negedge clk);
      cb("drained", 1'b0, evr);
      $display("Test full buffer finished");
      pl(1'b1, 1'b0);
      hits(3);
      clr();
      rc(TDCAB_OFS_ACQ, 32'he0000000, '1, 1'b0);
      n = 1 + {$random(seed)} % 8;
      pl(1'b1, 1'b0);
      hits(n);
      pl(1'b0, 1'b1);
      q.push_back(2 * n);
      ev_chk();
      $display("Test fast clear finished");
      complete_run();
   end
endmodule
`default_nettype wire
